/* pkg/mbmp_params.svh */
// constants for the mode based memory protection block
`ifndef MBMP_PARAMS_SVH
`define MBMP_PARAMS_SVH
`define MBMP_ADDR_W        24
`define MBMP_SEG_N         64
`define MBMP_SEG_IDX_W     6
// ------------------------------------------------------------
// fixed partition, physical windows
// ------------------------------------------------------------
`define MBMP_ROM_BASE      24'h00_0000
`define MBMP_ROM_TOP       24'h3F_FFFF
`define MBMP_RAM_BASE      24'h40_0000
`define MBMP_RAM_TOP       24'h7F_FFFF
`define MBMP_NVM_BASE      24'h80_0000
`define MBMP_NVM_TOP       24'hBF_FFFF
`define MBMP_PER_BASE      24'hC0_0000
`define MBMP_PER_TOP       24'hFF_FFFF
`define MBMP_CFG_ROW_BYTES 24'h00_0080
`define MBMP_TEST_PER_BASE 24'hFF_F000
// ------------------------------------------------------------
// exception vectors, one per source
// ------------------------------------------------------------
`define MBMP_VEC_BASE      24'h00_0100
`define MBMP_VEC_STEP      24'h00_0010
`define MBMP_PER_RIGHTS_W  8
`define MBMP_PER_GROUP_LSB 9
`endif

/* pkg/mbmp_pkg.sv */
// types for the mode based memory protection block
package mbmp_pkg;
  typedef enum logic [2:0] {
    MBMP_STARTUP, MBMP_FACTORY_TEST, MBMP_SUPPORT_FW, MBMP_PRIVILEGED, MBMP_UNPRIVILEGED
  } mbmp_mode_e;
  typedef enum logic [2:0] {
    MBMP_EXC_BREAKPOINT, MBMP_EXC_FAULT, MBMP_EXC_ILLEGAL, MBMP_EXC_STACK,
    MBMP_EXC_SYSCALL, MBMP_EXC_IRET, MBMP_EXC_VIOLATION, MBMP_EXC_COLLISION
  } mbmp_exc_e;
endpackage : mbmp_pkg

/* rtl/mbmp_seg_check.sv */
// segment table storage and parallel hit check for unprivileged accesses
`timescale 1ns/1ps
`include "mbmp_params.svh"
module mbmp_seg_check (
  input  wire logic                          ref_clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          wr_en_in,
  input  wire logic [`MBMP_SEG_IDX_W-1:0]    wr_idx_in,
  input  wire logic                          wr_enable_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       wr_vbase_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       wr_size_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       wr_pbase_in,
  input  wire logic [2:0]                    wr_rwx_in,
  input  wire logic [`MBMP_PER_RIGHTS_W-1:0] wr_per_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       addr_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       fetch_addr_in,
  output logic                               hit_out,
  output logic [2:0]                         rwx_out,
  output logic [`MBMP_ADDR_W-1:0]            paddr_out,
  output logic [`MBMP_PER_RIGHTS_W-1:0]      per_rights_out
);
  logic                          en_r    [`MBMP_SEG_N];
  logic [`MBMP_ADDR_W-1:0]       vbase_r [`MBMP_SEG_N];
  logic [`MBMP_ADDR_W-1:0]       size_r  [`MBMP_SEG_N];
  logic [`MBMP_ADDR_W-1:0]       pbase_r [`MBMP_SEG_N];
  logic [2:0]                    rwx_r   [`MBMP_SEG_N];
  logic [`MBMP_PER_RIGHTS_W-1:0] per_r   [`MBMP_SEG_N];
  logic [`MBMP_SEG_N-1:0]        hit_w;
  logic [`MBMP_SEG_N-1:0]        fhit_w;

  // ------------------------------------------------------------
  // per segment storage and match
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `MBMP_SEG_N; g++) begin : g_seg
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          en_r[g] <= 1'b0;
        end else if (wr_en_in && wr_idx_in == `MBMP_SEG_IDX_W'(g)) begin
          en_r[g]    <= wr_enable_in;
          vbase_r[g] <= wr_vbase_in;
          size_r[g]  <= wr_size_in;
          pbase_r[g] <= wr_pbase_in;
          rwx_r[g]   <= wr_rwx_in;
          per_r[g]   <= wr_per_in;
        end
      end
      assign hit_w[g]  = en_r[g] && addr_in >= vbase_r[g]
                         && (addr_in - vbase_r[g]) < size_r[g];
      assign fhit_w[g] = en_r[g] && fetch_addr_in >= vbase_r[g]
                         && (fetch_addr_in - vbase_r[g]) < size_r[g];
    end
  endgenerate

  // lowest index wins where segments overlap
  always_comb begin
    hit_out        = 1'b0;
    rwx_out        = 3'h0;
    paddr_out      = '0;
    per_rights_out = '0;
    for (int i = `MBMP_SEG_N - 1; i >= 0; i--) begin
      if (hit_w[i]) begin
        hit_out   = 1'b1;
        rwx_out   = rwx_r[i];
        paddr_out = pbase_r[i] + (addr_in - vbase_r[i]);
      end
      if (fhit_w[i]) begin
        per_rights_out = per_r[i];
      end
    end
  end
endmodule : mbmp_seg_check

/* rtl/mbmp_protect.sv */
// mode tracking, address translation and exception entry for the core
`timescale 1ns/1ps
`include "mbmp_params.svh"
// ------------------------------------------------------------
// Overview of operation
// - five modes: startup, factory test, support firmware, privileged, unprivileged.
// - every reset enters startup mode; application code can never enter it.
// - application requests to enter support firmware mode are denied.
// - factory test unlocks test registers; a one-way fuse disables it forever.
// - elevated firmware flag is high in startup, factory test or support firmware.
// - privileged mode reaches the fixed partition except test registers at MBMP_TEST_PER_BASE and up, and may write translation setup.
// - unprivileged accesses need a segment; peripheral access is limited by rights.
// - every virtual address below MBMP_PER_BASE maps to a physical RAM, ROM or non-volatile address.
// - sixty-four segments at most; the partition itself is fixed.
// - each segment has base, size, enable and read, write, execute permissions.
// - segment peripheral rights apply to code fetched from that segment.
// - segments live in RAM, ROM or non-volatile memory; others are denied.
// - the descriptor table may be loaded from any privileged-reachable address.
// - exceptions are ignored in elevated modes, otherwise vector by source and enter privileged mode.
// - eight sources raise exceptions, including breakpoints, faults and violations.
// - top 128 bytes of non-volatile memory form the protected configuration row; the code only flags accesses to it on cfg_row_out and does not block them.
// ------------------------------------------------------------
module mbmp_protect (
  input  wire logic                          ref_clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          acc_valid_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       acc_addr_in,
  input  wire logic                          acc_write_in,
  input  wire logic                          acc_exec_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       fetch_addr_in,
  input  wire logic                          startup_done_in,
  input  wire logic                          test_entry_in,
  input  wire logic                          test_fuse_blow_in,
  input  wire logic                          support_fw_entry_in,
  input  wire logic                          app_support_req_in,
  input  wire logic                          drop_to_unpriv_in,
  input  wire logic                          mode_return_in,
  input  wire logic                          seg_wr_in,
  input  wire logic [`MBMP_SEG_IDX_W-1:0]    seg_idx_in,
  input  wire logic                          seg_enable_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       seg_vbase_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       seg_size_in,
  input  wire logic [`MBMP_ADDR_W-1:0]       seg_pbase_in,
  input  wire logic [2:0]                    seg_rwx_in,
  input  wire logic [`MBMP_PER_RIGHTS_W-1:0] seg_per_in,
  input  wire logic                          exc_breakpoint_in,
  input  wire logic                          exc_fault_in,
  input  wire logic                          exc_illegal_in,
  input  wire logic                          exc_stack_in,
  input  wire logic                          exc_syscall_in,
  input  wire logic                          iret_exec_in,
  input  wire logic                          collision_in,
  output logic                               grant_out,
  output logic [`MBMP_ADDR_W-1:0]            paddr_out,
  output logic                               cfg_row_out,
  output logic [2:0]                         mode_out,
  output logic                               elevated_out,
  output logic                               test_regs_open_out,
  output logic                               test_disabled_out,
  output logic                               exc_out,
  output logic [2:0]                         exc_src_out,
  output logic [`MBMP_ADDR_W-1:0]            exc_vector_out
);
  mbmp_pkg::mbmp_mode_e mode_r, mode_nxt;
  mbmp_pkg::mbmp_mode_e ret_mode_r;
  logic                 test_fuse_r = 1'b0;
  logic                 exc_r;
  logic [2:0]           exc_src_r;
  logic [`MBMP_ADDR_W-1:0] vec_r;
  logic [`MBMP_ADDR_W-1:0] paddr_r;
  logic                 grant_r;
  logic                 cfg_row_r;

  // ------------------------------------------------------------
  // segment table, up to sixty-four entries
  // ------------------------------------------------------------
  logic                          seg_hit_w;
  logic [2:0]                    seg_rwx_w;
  logic [`MBMP_ADDR_W-1:0]       seg_paddr_w;
  logic [`MBMP_PER_RIGHTS_W-1:0] seg_rights_w;
  wire  unpriv_w   = (mode_r == mbmp_pkg::MBMP_UNPRIVILEGED);
  wire  priv_w     = (mode_r == mbmp_pkg::MBMP_PRIVILEGED);
  wire  elevated_w = (mode_r == mbmp_pkg::MBMP_STARTUP) ||
                     (mode_r == mbmp_pkg::MBMP_FACTORY_TEST) ||
                     (mode_r == mbmp_pkg::MBMP_SUPPORT_FW);
  // table may be loaded from anywhere, the core copies it in via these writes
  wire  cfg_wr_ok_w = seg_wr_in && (priv_w || elevated_w);

  mbmp_seg_check u_seg (
    .ref_clk_in     (ref_clk_in),
    .sys_rst_in     (sys_rst_in),
    .wr_en_in       (cfg_wr_ok_w),
    .wr_idx_in      (seg_idx_in),
    .wr_enable_in   (seg_enable_in),
    .wr_vbase_in    (seg_vbase_in),
    .wr_size_in     (seg_size_in),
    .wr_pbase_in    (seg_pbase_in),
    .wr_rwx_in      (seg_rwx_in),
    .wr_per_in      (seg_per_in),
    .addr_in        (acc_addr_in),
    .fetch_addr_in  (fetch_addr_in),
    .hit_out        (seg_hit_w),
    .rwx_out        (seg_rwx_w),
    .paddr_out      (seg_paddr_w),
    .per_rights_out (seg_rights_w)
  );

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  wire  is_per_w   = acc_addr_in >= `MBMP_PER_BASE;
  wire  is_test_w  = acc_addr_in >= `MBMP_TEST_PER_BASE;
  wire  [2:0] per_grp_w = acc_addr_in[`MBMP_PER_GROUP_LSB+2:`MBMP_PER_GROUP_LSB];
  wire  per_ok_w   = seg_rights_w[per_grp_w] && !is_test_w;
  wire  perm_ok_w  = acc_exec_in ? seg_rwx_w[0] :
                     acc_write_in ? seg_rwx_w[1] : seg_rwx_w[2];
  wire  phys_mem_w = seg_paddr_w <= `MBMP_NVM_TOP;
  wire  test_mode_w = (mode_r == mbmp_pkg::MBMP_FACTORY_TEST) && !test_fuse_r;
  wire  unpriv_ok_w = is_per_w ? per_ok_w
                      : (seg_hit_w && perm_ok_w && phys_mem_w);
  wire  priv_ok_w  = !is_test_w || test_mode_w;
  wire  acc_ok_w   = unpriv_w ? unpriv_ok_w : priv_ok_w;
  wire  [`MBMP_ADDR_W-1:0] xlat_w = (unpriv_w && !is_per_w) ? seg_paddr_w
                                                            : acc_addr_in;
  wire  viol_w = acc_valid_in && !acc_ok_w;
  wire  cfg_viol_w = seg_wr_in && unpriv_w;
  wire  iret_viol_w = iret_exec_in && unpriv_w;

  // priority encode of sources, lowest index first; all are ignored in elevated modes
  wire  [7:0] src_w = {collision_in, viol_w || cfg_viol_w, iret_viol_w, exc_syscall_in,
                       exc_stack_in, exc_illegal_in, exc_fault_in, exc_breakpoint_in};
  logic [2:0] src_idx_w;
  always_comb begin
    src_idx_w = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (src_w[i]) begin
        src_idx_w = 3'(i);
      end
    end
  end
  wire  any_exc_w = |src_w;

  // ------------------------------------------------------------
  // mode state machine
  // ------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      mbmp_pkg::MBMP_STARTUP: begin
        if (test_entry_in && !test_fuse_r) begin
          mode_nxt = mbmp_pkg::MBMP_FACTORY_TEST;
        end else if (startup_done_in) begin
          mode_nxt = mbmp_pkg::MBMP_PRIVILEGED;
        end
      end
      mbmp_pkg::MBMP_FACTORY_TEST: begin
        if (test_fuse_r || startup_done_in) begin
          mode_nxt = mbmp_pkg::MBMP_PRIVILEGED;
        end
      end
      mbmp_pkg::MBMP_SUPPORT_FW: begin
        if (mode_return_in) begin
          mode_nxt = ret_mode_r;
        end
      end
      mbmp_pkg::MBMP_PRIVILEGED: begin
        // application asked; entry only by the vendor firmware path
        if (support_fw_entry_in && !app_support_req_in) begin
          mode_nxt = mbmp_pkg::MBMP_SUPPORT_FW;
        end else if (drop_to_unpriv_in) begin
          mode_nxt = mbmp_pkg::MBMP_UNPRIVILEGED;
        end
      end
      mbmp_pkg::MBMP_UNPRIVILEGED: begin
        mode_nxt = mbmp_pkg::MBMP_UNPRIVILEGED;
      end
      default: mode_nxt = mbmp_pkg::MBMP_STARTUP;
    endcase
    if (any_exc_w && !elevated_w) begin
      mode_nxt = mbmp_pkg::MBMP_PRIVILEGED;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mode_r     <= mbmp_pkg::MBMP_STARTUP;
      ret_mode_r <= mbmp_pkg::MBMP_PRIVILEGED;
    end else begin
      mode_r <= mode_nxt;
      if (mode_nxt == mbmp_pkg::MBMP_SUPPORT_FW && mode_r != mbmp_pkg::MBMP_SUPPORT_FW) begin
        ret_mode_r <= mode_r;
      end
    end
  end

  // one-way fuse model: reset cannot clear it, so it survives warm resets
  // limitation: power-up value must come from a real fuse in silicon
  always_ff @(posedge ref_clk_in) begin
    if (test_fuse_blow_in && mode_r == mbmp_pkg::MBMP_FACTORY_TEST) begin
      test_fuse_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // registered outputs, plus flags decoded from mode_r and the fuse
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      exc_r     <= 1'b0;
      exc_src_r <= 3'h0;
      vec_r     <= '0;
      grant_r   <= 1'b0;
      paddr_r   <= '0;
      cfg_row_r <= 1'b0;
    end else begin
      exc_r     <= any_exc_w && !elevated_w;
      exc_src_r <= src_idx_w;
      vec_r     <= `MBMP_VEC_BASE + `MBMP_VEC_STEP * {21'h0, src_idx_w};
      grant_r   <= acc_valid_in && acc_ok_w;
      paddr_r   <= xlat_w;
      cfg_row_r <= xlat_w >= (`MBMP_NVM_TOP - `MBMP_CFG_ROW_BYTES + 24'h00_0001)
                   && xlat_w <= `MBMP_NVM_TOP;
    end
  end

  assign grant_out          = grant_r;
  assign paddr_out          = paddr_r;
  assign cfg_row_out        = cfg_row_r;
  assign mode_out           = mode_r;
  assign elevated_out       = elevated_w;
  assign test_regs_open_out = test_mode_w;
  assign test_disabled_out  = test_fuse_r;
  assign exc_out            = exc_r;
  assign exc_src_out        = exc_src_r;
  assign exc_vector_out     = vec_r;
endmodule : mbmp_protect

/* verif/mbmp_protect_checker.sv */
// port level assertions for the protection block
`timescale 1ns/1ps
`include "mbmp_params.svh"
module mbmp_protect_checker (
  input  wire logic                    ref_clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    test_entry_in,
  input  wire logic                    support_fw_entry_in,
  input  wire logic                    app_support_req_in,
  input  wire logic                    seg_wr_in,
  input  wire logic                    exc_breakpoint_in,
  input  wire logic                    exc_fault_in,
  input  wire logic                    exc_illegal_in,
  input  wire logic                    exc_stack_in,
  input  wire logic                    exc_syscall_in,
  input  wire logic                    iret_exec_in,
  input  wire logic [2:0]              mode_out,
  input  wire logic                    elevated_out,
  input  wire logic                    test_regs_open_out,
  input  wire logic                    test_disabled_out,
  input  wire logic                    exc_out,
  input  wire logic [2:0]              exc_src_out,
  input  wire logic [`MBMP_ADDR_W-1:0] exc_vector_out
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // a higher priority source would mask the violation code
  wire logic hi_exc = exc_breakpoint_in | exc_fault_in | exc_illegal_in | exc_stack_in |
                      exc_syscall_in | iret_exec_in;
  a_reset_startup: assert property (disable iff (1'b0) sys_rst_in |=> mode_out == 3'h0)
    else $error("mode not startup after reset");
  a_startup_unreach: assert property (mode_out != 3'h0 |=> mode_out != 3'h0)
    else $error("startup mode reached without reset");
  a_elevated_map: assert property (elevated_out == (mode_out < 3'h3))
    else $error("elevated flag disagrees with mode");
  a_support_denied: assert property (mode_out == 3'h3 && support_fw_entry_in &&
    app_support_req_in |=> mode_out != 3'h2)
    else $error("application entered support firmware mode");
  a_test_locked: assert property (test_disabled_out && mode_out == 3'h0 &&
    test_entry_in |=> mode_out != 3'h1 && test_disabled_out)
    else $error("test mode entered after fuse");
  a_test_regs_gate: assert property (test_regs_open_out |-> mode_out == 3'h1)
    else $error("test registers open outside test mode");
  a_vector_src: assert property (exc_out |-> mode_out == 3'h3 &&
    exc_vector_out == 24'h00_0100 + {17'h0, exc_src_out, 4'h0})
    else $error("exception vector or mode wrong");
  a_break_taken: assert property (mode_out > 3'h2 && exc_breakpoint_in |=>
    exc_out && exc_src_out == 3'h0)
    else $error("breakpoint exception not taken");
  a_unpriv_cfgwr: assert property (mode_out == 3'h4 && seg_wr_in && !hi_exc |=>
    exc_out && exc_src_out == 3'h6)
    else $error("unprivileged segment write not flagged");
  c_support: cover property (mode_out == 3'h2);
  c_collision: cover property (exc_out && exc_src_out == 3'h7);
  c_fused: cover property (test_disabled_out && mode_out == 3'h0);
endmodule : mbmp_protect_checker
bind mbmp_protect mbmp_protect_checker chk_u (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .test_entry_in(test_entry_in),
  .support_fw_entry_in(support_fw_entry_in), .app_support_req_in(app_support_req_in),
  .seg_wr_in(seg_wr_in), .exc_breakpoint_in(exc_breakpoint_in), .exc_fault_in(exc_fault_in),
  .exc_illegal_in(exc_illegal_in), .exc_stack_in(exc_stack_in),
  .exc_syscall_in(exc_syscall_in), .iret_exec_in(iret_exec_in), .mode_out(mode_out),
  .elevated_out(elevated_out), .test_regs_open_out(test_regs_open_out),
  .test_disabled_out(test_disabled_out), .exc_out(exc_out), .exc_src_out(exc_src_out),
  .exc_vector_out(exc_vector_out));

/* verif/mbmp_core_model.sv */
// processor core model issuing one virtual access at a time
`timescale 1ns/1ps
module mbmp_core_model (
  input  wire logic  ref_clk_in,
  output logic       acc_valid_out,
  output logic [23:0] acc_addr_out,
  output logic       acc_write_out,
  output logic       acc_exec_out,
  output logic [23:0] fetch_addr_out
);
  initial begin
    acc_valid_out = 1'b0;
    acc_addr_out = 24'h00_0000;
    acc_write_out = 1'b0;
    acc_exec_out = 1'b0;
    fetch_addr_out = 24'h00_0000;
  end
  // one cycle request; the released address is inverted so stale values never match
  task automatic issue(input logic [23:0] a, input logic w, input logic x, input logic [23:0] f);
    @(posedge ref_clk_in);
    acc_valid_out <= 1'b1;
    acc_addr_out <= a;
    acc_write_out <= w;
    acc_exec_out <= x;
    fetch_addr_out <= f;
    @(posedge ref_clk_in);
    acc_valid_out <= 1'b0;
    acc_addr_out <= ~a;
    acc_write_out <= 1'b0;
    #1;
  endtask : issue
endmodule : mbmp_core_model

/* verif/testbench.sv */
// self checking bench for the protection block
`timescale 1ns/1ps
module testbench;
  logic clk, rst, app;
  logic [13:0] ctl;
  logic [5:0]  sidx;
  logic [23:0] svb, ssz, spb, pa, vec;
  logic [7:0]  sper;
  logic [2:0]  srwx, mode, src;
  logic        grant, cfg, elev, topen, tdis, exc;
  logic        sen;
  wire logic   av, aw, ax;
  wire logic [23:0] aa, fa;
  int          bad_count, check_count;
  mbmp_core_model core_u (.ref_clk_in(clk), .acc_valid_out(av), .acc_addr_out(aa),
    .acc_write_out(aw), .acc_exec_out(ax), .fetch_addr_out(fa));
  mbmp_protect dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .acc_valid_in(av), .acc_addr_in(aa),
    .acc_write_in(aw), .acc_exec_in(ax), .fetch_addr_in(fa), .startup_done_in(ctl[0]),
    .test_entry_in(ctl[1]), .test_fuse_blow_in(ctl[2]), .support_fw_entry_in(ctl[3]),
    .app_support_req_in(app), .drop_to_unpriv_in(ctl[4]), .mode_return_in(ctl[5]),
    .seg_wr_in(ctl[13]), .seg_idx_in(sidx), .seg_enable_in(sen), .seg_vbase_in(svb),
    .seg_size_in(ssz), .seg_pbase_in(spb), .seg_rwx_in(srwx), .seg_per_in(sper),
    .exc_breakpoint_in(ctl[6]), .exc_fault_in(ctl[7]), .exc_illegal_in(ctl[8]),
    .exc_stack_in(ctl[9]), .exc_syscall_in(ctl[10]), .iret_exec_in(ctl[11]),
    .collision_in(ctl[12]), .grant_out(grant), .paddr_out(pa), .cfg_row_out(cfg),
    .mode_out(mode), .elevated_out(elev), .test_regs_open_out(topen),
    .test_disabled_out(tdis), .exc_out(exc), .exc_src_out(src), .exc_vector_out(vec));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic pulse(input int b);
    @(posedge clk);
    ctl <= 14'(1) << b;
    @(posedge clk);
    ctl <= '0;
    #1;
  endtask : pulse
  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic deny;
    chk(grant, 0);
    chk(exc, 1);
    chk(src, 6);
    chk(vec, 24'h00_0160);
    chk(mode, 3);
  endtask : deny
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_modes;
    chk(mode, 0);
    chk(elev, 1);
    pulse(1);
    chk(mode, 1);
    chk(topen, 1);
    core_u.issue(24'hFF_F000, 1'b0, 1'b0, 24'h00_0000);
    chk(grant, 1);
    pulse(0);
    chk(mode, 3);
    chk(elev, 0);
    chk(topen, 0);
    core_u.issue(24'hFF_F000, 1'b0, 1'b0, 24'h00_0000);
    chk(grant, 0);
    core_u.issue(24'hBF_FF80, 1'b0, 1'b0, 24'h00_0000);
    chk(grant, 1);
    chk(cfg, 1);
    core_u.issue(24'hBF_FF7F, 1'b0, 1'b0, 24'h00_0000);
    chk(cfg, 0);
    @(posedge clk) app <= 1'b1;
    pulse(3);
    chk(mode, 3);
    @(posedge clk) app <= 1'b0;
    pulse(3);
    chk(mode, 2);
    chk(elev, 1);
    pulse(5);
    chk(mode, 3);
  endtask : t_modes
  // highest index proves all sixty-four slots exist; read only, one peripheral group
  task automatic t_segments;
    @(posedge clk);
    {sidx, sen, svb, ssz} <= {6'h3F, 1'b1, 24'h01_0000, 24'h00_1000};
    {spb, srwx, sper} <= {24'h40_2000, 3'b100, 8'h01};
    pulse(13);
    pulse(4);
    chk(mode, 4);
    core_u.issue(24'h01_0010, 1'b0, 1'b0, 24'h01_0000);
    chk(grant, 1);
    chk(pa, 24'h40_2010);
    core_u.issue(24'hC0_0000, 1'b0, 1'b0, 24'h01_0000);
    chk(grant, 1);
    core_u.issue(24'hC0_0200, 1'b0, 1'b0, 24'h01_0000);
    deny();
    pulse(4);
    core_u.issue(24'h01_0010, 1'b1, 1'b0, 24'h01_0000);
    deny();
    pulse(4);
    core_u.issue(24'h02_0000, 1'b0, 1'b0, 24'h01_0000);
    deny();
    pulse(4);
    core_u.issue(24'h01_0010, 1'b0, 1'b1, 24'h01_0000);
    deny();
  endtask : t_segments
  task automatic t_exceptions;
    for (int i = 0; i < 8; i++) begin
      pulse(4);
      pulse(i == 6 ? 13 : (i == 7 ? 12 : 6 + i));
      chk(exc, 1);
      chk(src, 24'(i));
      chk(vec, 24'h00_0100 + 24'(16 * i));
      chk(mode, 3);
    end
  endtask : t_exceptions
  task automatic t_fuse;
    do_reset(2);
    pulse(1);
    chk(mode, 1);
    pulse(2);
    chk(tdis, 1);
    do_reset(2);
    pulse(1);
    chk(mode, 0);
    chk(tdis, 1);
  endtask : t_fuse
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, app, ctl, sidx, sen, svb, ssz, spb, srwx, sper} = '0;
    rst = 1'b1;
    do_reset(12);
    #1;
    t_modes();
    t_segments();
    t_exceptions();
    t_fuse();
    give_verdict();
  end
  initial begin
    #2_000_000;
    bad_count++;
    give_verdict();
  end
endmodule : testbench
